// ===== logic/grts_top.sv
// Our own choice: the strobed register port.
`timescale 1ns/1ns
`default_nettype none
module grts_top
  import grts_pkg::*;
#(
  parameter int NUM_CHAN = GRTS_NUM_CHAN
)
(
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire logic [7:0]          addr,
  input  wire logic [7:0]          wdata,
  input  wire logic                wr,
  input  wire logic                rd,
  input  wire logic                e1_mode,
  output logic [7:0]               rdata,
  output grts_wire_t               wire_size,
  output grts_slice_t              slicer_trim,
  output grts_eq_t                 eq_gain_trim,
  output logic [NUM_CHAN-1:0]      chan_custom_shape,
  output logic [NUM_CHAN-1:0]      chan_std_e1_shape
);

  // ****************************************
  // elaboration checks
  // ****************************************
  // catch package edits that the fixed two-bit decode cannot follow
  if (NUM_CHAN < 1 || NUM_CHAN > 16)
  begin : g_bad_chan
    $error("NUM_CHAN out of range");
  end

  // fields are two bits wide, so a position tops out at 6
  if (GRTS_WIRE_POS < 0 || GRTS_WIRE_POS > 6)
  begin : g_bad_wire
    $error("wire size field outside register");
  end

  if (GRTS_SLICER_POS < 0 || GRTS_SLICER_POS > 6)
  begin : g_bad_slicer
    $error("slicer field outside register");
  end

  if (GRTS_EQ_POS < 0 || GRTS_EQ_POS > 6)
  begin : g_bad_eq
    $error("eq gain field outside register");
  end

  if (GRTS_ENABLE_POS < 0 || GRTS_ENABLE_POS > 7)
  begin : g_bad_enable
    $error("shape enable bit outside register");
  end

  // overlapping fields would let one write steer two controls
  if (GRTS_SLICER_POS + 2 > GRTS_WIRE_POS || GRTS_EQ_POS + 2 > GRTS_SLICER_POS)
  begin : g_overlap
    $error("tuning fields overlap");
  end

  // one shared address would let the rx_tune branch take every write and read, leaving shape unreachable
  if (GRTS_ADDR_RX_TUNE == GRTS_ADDR_SHAPE)
  begin : g_same_addr
    $error("register addresses collide");
  end

  // outputs clear to zero, which only matches these reset values
  if (GRTS_RST_RX_TUNE != 8'h00 || GRTS_RST_SHAPE[GRTS_ENABLE_POS] != 1'b0)
  begin : g_bad_reset
    $error("reset values disagree with cleared outputs");
  end

  // ****************************************
  // register file
  // ****************************************
  // strobes pass straight through; the bank never stalls the master
  grts_bus_if bus ();
  logic [7:0] rx_tune;
  logic [7:0] shape;

  assign bus.addr  = addr;
  assign bus.wdata = wdata;
  assign bus.wr    = wr;
  assign bus.rd    = rd;
  assign rdata     = bus.rdata;

  grts_regs u_regs
  (
    .clk     (clk),
    .rst     (rst),
    .bus     (bus),
    .rx_tune (rx_tune),
    .shape   (shape)
  );

  // ****************************************
  // field bits
  // ****************************************
  // the bank hands over raw bytes; field bits are picked here
  logic wire_size_sel_hi;
  logic wire_size_sel_lo;
  logic slicer_trim_hi;
  logic slicer_trim_lo;
  logic eq_gain_trim_hi;
  logic eq_gain_trim_lo;

  // the two reserved bits between the fields are stored but steer nothing
  assign wire_size_sel_hi = rx_tune[GRTS_WIRE_POS + 1];
  assign wire_size_sel_lo = rx_tune[GRTS_WIRE_POS];
  assign slicer_trim_hi   = rx_tune[GRTS_SLICER_POS + 1];
  assign slicer_trim_lo   = rx_tune[GRTS_SLICER_POS];
  assign eq_gain_trim_hi  = rx_tune[GRTS_EQ_POS + 1];
  assign eq_gain_trim_lo  = rx_tune[GRTS_EQ_POS];

  // ****************************************
  // decode
  // ****************************************
  // one register stage of decode: outputs lag a write by a cycle
  function automatic grts_wire_t wire_dec(input logic hi, input logic lo);
    case ({hi, lo})
      2'h1:    wire_dec = GRTS_WIRE_22;
      2'h2:    wire_dec = GRTS_WIRE_24;
      2'h3:    wire_dec = GRTS_WIRE_26;
      default: wire_dec = GRTS_WIRE_22_24;
    endcase
  endfunction

  // code 11 falls back to normal in both trim fields
  function automatic grts_slice_t slice_dec(input logic [1:0] f);
    case (f)
      2'h1:    slice_dec = GRTS_SLICE_LOWER;
      2'h2:    slice_dec = GRTS_SLICE_RAISE;
      2'h3:    slice_dec = GRTS_SLICE_NORMAL;
      default: slice_dec = GRTS_SLICE_NORMAL;
    endcase
  endfunction

  function automatic grts_eq_t eq_dec(input logic [1:0] f);
    case (f)
      2'h1:    eq_dec = GRTS_EQ_CUT1DB;
      2'h2:    eq_dec = GRTS_EQ_CUT3DB;
      2'h3:    eq_dec = GRTS_EQ_NORMAL;
      default: eq_dec = GRTS_EQ_NORMAL;
    endcase
  endfunction

  // one level fanned out to every channel's shaper
  function automatic logic [NUM_CHAN-1:0] fan_out(input logic level);
    fan_out = {NUM_CHAN{level}};
  endfunction

  // ****************************************
  // decoded state
  // ****************************************
  typedef struct packed
  {
    grts_wire_t          wire_size;
    grts_slice_t         slicer_trim;
    grts_eq_t            eq_gain_trim;
    logic [NUM_CHAN-1:0] custom;
    logic [NUM_CHAN-1:0] std_e1;
  } grts_top_state_t;

  grts_top_state_t st;
  grts_top_state_t next_st;
  logic            custom_pulse_shape_enable;

  assign custom_pulse_shape_enable = shape[GRTS_ENABLE_POS];

  always_comb
  begin
    next_st = st;
    next_st.wire_size    = wire_dec(wire_size_sel_hi, wire_size_sel_lo);
    next_st.slicer_trim  = slice_dec({slicer_trim_hi, slicer_trim_lo});
    next_st.eq_gain_trim = eq_dec({eq_gain_trim_hi, eq_gain_trim_lo});
    // per-channel waveform itself lives in each channel's own shaper
    // outside E1 neither shaping mode is asked for
    next_st.custom = fan_out(e1_mode && custom_pulse_shape_enable);
    next_st.std_e1 = fan_out(e1_mode && !custom_pulse_shape_enable);
  end

  // ****************************************
  // state register
  // ****************************************
  // reset gives the decoded meaning of all-zero tuning fields; both shape vectors clear, even with e1_mode high
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st.wire_size    <= GRTS_WIRE_22_24;
      st.slicer_trim  <= GRTS_SLICE_NORMAL;
      st.eq_gain_trim <= GRTS_EQ_NORMAL;
      st.custom       <= '0;
      st.std_e1       <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  // every decoded output comes straight off the state register
  assign wire_size         = st.wire_size;
  assign slicer_trim       = st.slicer_trim;
  assign eq_gain_trim      = st.eq_gain_trim;
  assign chan_custom_shape = st.custom;
  assign chan_std_e1_shape = st.std_e1;

endmodule
`default_nettype wire

// ===== logic/grts_pkg.sv
package grts_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] GRTS_ADDR_RX_TUNE = 8'h80;
  localparam logic [7:0] GRTS_ADDR_SHAPE   = 8'hC0;
  localparam logic [7:0] GRTS_RST_RX_TUNE  = 8'h00;
  localparam logic [7:0] GRTS_RST_SHAPE    = 8'h00;
  localparam int         GRTS_WIRE_POS     = 6;
  localparam int         GRTS_SLICER_POS   = 2;
  localparam int         GRTS_EQ_POS       = 0;
  localparam int         GRTS_ENABLE_POS   = 0;
  localparam int         GRTS_NUM_CHAN     = 8;

  // ****************************************
  // decoded settings
  // ****************************************
  typedef enum logic [1:0]
  {
    GRTS_WIRE_22_24 = 2'h0,
    GRTS_WIRE_22    = 2'h1,
    GRTS_WIRE_24    = 2'h2,
    GRTS_WIRE_26    = 2'h3
  } grts_wire_t;

  typedef enum logic [1:0]
  {
    GRTS_SLICE_NORMAL = 2'h0,
    GRTS_SLICE_LOWER  = 2'h1,
    GRTS_SLICE_RAISE  = 2'h2
  } grts_slice_t;

  typedef enum logic [1:0]
  {
    GRTS_EQ_NORMAL = 2'h0,
    GRTS_EQ_CUT1DB = 2'h1,
    GRTS_EQ_CUT3DB = 2'h2
  } grts_eq_t;

endpackage

// ===== logic/grts_bus_if.sv
`timescale 1ns/1ns
`default_nettype none
interface grts_bus_if;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;
  modport master (output addr, output wdata, output wr, output rd, input rdata);
  modport slave  (input addr, input wdata, input wr, input rd, output rdata);
endinterface
`default_nettype wire

// ===== logic/grts_regs.sv
`timescale 1ns/1ns
`default_nettype none
module grts_regs
  import grts_pkg::*;
(
  input  wire logic   clk,
  input  wire logic   rst,
  grts_bus_if.slave   bus,
  output logic [7:0]  rx_tune,
  output logic [7:0]  shape
);

  typedef struct packed
  {
    logic [7:0] rx_tune;
    logic [7:0] shape;
    logic [7:0] rdata;
  } grts_regs_state_t;

  grts_regs_state_t st;
  grts_regs_state_t next_st;

  always_comb
  begin
    next_st = st;
    next_st.rdata = 8'h00;
    if (bus.wr && bus.addr == GRTS_ADDR_RX_TUNE)
    begin
      next_st.rx_tune = bus.wdata;
    end
    else if (bus.wr && bus.addr == GRTS_ADDR_SHAPE)
    begin
      next_st.shape = bus.wdata;
    end
    // unmapped reads return zero
    if (bus.rd && bus.addr == GRTS_ADDR_RX_TUNE)
    begin
      next_st.rdata = st.rx_tune;
    end
    else if (bus.rd && bus.addr == GRTS_ADDR_SHAPE)
    begin
      next_st.rdata = st.shape;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st <= '{GRTS_RST_RX_TUNE, GRTS_RST_SHAPE, 8'h00};
    end
    else
    begin
      st <= next_st;
    end
  end

  assign bus.rdata = st.rdata;
  assign rx_tune   = st.rx_tune;
  assign shape     = st.shape;

endmodule
`default_nettype wire

// ===== verif/grts_top_props.sv
`timescale 1ns/1ns
`default_nettype none
module grts_top_props
  import grts_pkg::*;
#(
  parameter int NUM_CHAN = GRTS_NUM_CHAN
)
(
  input wire logic                clk,
  input wire logic                rst,
  input wire logic [7:0]          addr,
  input wire logic [7:0]          wdata,
  input wire logic                wr,
  input wire logic                rd,
  input wire logic                e1_mode,
  input wire logic [7:0]          rdata,
  input wire logic [1:0]          wire_size,
  input wire logic [1:0]          slicer_trim,
  input wire logic [1:0]          eq_gain_trim,
  input wire logic [NUM_CHAN-1:0] chan_custom_shape,
  input wire logic [NUM_CHAN-1:0] chan_std_e1_shape
);
  // ****
  // checks
  // ****
  function automatic logic [1:0] fold(logic [1:0] f);
    return (f == 2'h3) ? 2'h0 : f;
  endfunction
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic wt;
  logic wc;
  assign wt = wr && (addr == GRTS_ADDR_RX_TUNE);
  assign wc = wr && (addr == GRTS_ADDR_SHAPE);
  logic rd_hit;
  assign rd_hit = rd && (addr == GRTS_ADDR_RX_TUNE || addr == GRTS_ADDR_SHAPE);
  wire_a: assert property ($past(wt) |=> wire_size == $past(wdata[7:6], 2))
    else $error("wire size");
  slice_a: assert property ($past(wt) |=> slicer_trim == fold($past(wdata[3:2], 2)))
    else $error("slicer trim");
  eq_a: assert property ($past(wt) |=> eq_gain_trim == fold($past(wdata[1:0], 2)))
    else $error("eq trim");
  cust_a: assert property ($past(wc) && e1_mode |=>
    chan_custom_shape == {NUM_CHAN{$past(wdata[0], 2)}})
    else $error("custom shape");
  std_wr_a: assert property ($past(wc) && e1_mode |=>
    chan_std_e1_shape == {NUM_CHAN{!$past(wdata[0], 2)}})
    else $error("std shape after write");
  // sampled rst skips the still-clear cycle just after release
  std_a: assert property (e1_mode && !rst |=> chan_std_e1_shape == ~chan_custom_shape)
    else $error("std shape");
  no_e1_a: assert property (!e1_mode && !rst |=>
    chan_custom_shape == '0 && chan_std_e1_shape == '0)
    else $error("shape outside E1");
  rdw_a: assert property (rd && addr == GRTS_ADDR_RX_TUNE |=> rdata[7:6] == wire_size)
    else $error("tune readback");
  rdc_a: assert property (rd && addr == GRTS_ADDR_SHAPE && e1_mode |=>
    rdata[0] == chan_custom_shape[0])
    else $error("shape readback");
  idle_a: assert property (!rd_hit |=> rdata == 8'h00)
    else $error("idle rdata");
  cover property (wt);
  cover property (wc && wdata[0] && e1_mode);
  cover property (rd && addr == GRTS_ADDR_SHAPE);
endmodule
bind grts_top grts_top_props #(.NUM_CHAN(NUM_CHAN)) u_props (.clk(clk), .rst(rst), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .e1_mode(e1_mode), .rdata(rdata), .wire_size(wire_size),
  .slicer_trim(slicer_trim), .eq_gain_trim(eq_gain_trim),
  .chan_custom_shape(chan_custom_shape), .chan_std_e1_shape(chan_std_e1_shape));
`default_nettype wire

// ===== verif/grts_top_bench.sv
`timescale 1ns/1ns
`default_nettype none
module grts_top_bench;
  import grts_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        e1_mode = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [7:0]  wdata = 8'h00;
  logic [7:0]  rdata;
  logic [7:0]  cust;
  logic [7:0]  stdp;
  grts_wire_t  wire_size;
  grts_slice_t slicer_trim;
  grts_eq_t    eq_gain_trim;
  int          mismatches = 0;
  int          total_checks = 0;
  grts_top u_dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .e1_mode(e1_mode), .rdata(rdata), .wire_size(wire_size), .slicer_trim(slicer_trim),
    .eq_gain_trim(eq_gain_trim), .chan_custom_shape(cust), .chan_std_e1_shape(stdp));
  // ****
  // tasks
  // ****
  initial forever #25 clk = ~clk;
  task chk(string n, logic [7:0] e, logic [7:0] g);
    total_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // decoded outputs land two edges after the write strobe
  task wr_reg(logic [7:0] a, logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
    #1;
  endtask
  task rd_reg(logic [7:0] a, logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk("rdata", e, rdata);
  endtask
  task t_tune;
    for (int i = 0; i < 4; i++)
    begin
      wr_reg(GRTS_ADDR_RX_TUNE, 8'(i * 85));
      chk("wire", 8'(i), 8'(wire_size));
      chk("slicer", (i == 3) ? 8'h00 : 8'(i), 8'(slicer_trim));
      chk("eq", (i == 3) ? 8'h00 : 8'(i), 8'(eq_gain_trim));
      rd_reg(GRTS_ADDR_RX_TUNE, 8'(i * 85));
    end
    $display("tune done");
  endtask
  task t_shape;
    @(posedge clk);
    e1_mode <= 1'b1;
    wr_reg(GRTS_ADDR_SHAPE, 8'hFF);
    chk("custom", 8'hFF, cust);
    chk("std", 8'h00, stdp);
    rd_reg(GRTS_ADDR_SHAPE, 8'hFF);
    wr_reg(GRTS_ADDR_SHAPE, 8'hFE);
    chk("custom", 8'h00, cust);
    chk("std", 8'hFF, stdp);
    @(posedge clk);
    e1_mode <= 1'b0;
    @(posedge clk);
    #1;
    chk("std", 8'h00, stdp);
    chk("custom", 8'h00, cust);
    $display("shape done");
  endtask
  task t_misc;
    rd_reg(GRTS_ADDR_SHAPE, GRTS_RST_SHAPE);
    rd_reg(GRTS_ADDR_RX_TUNE, GRTS_RST_RX_TUNE);
    wr_reg(8'h81, 8'h12);
    rd_reg(8'h81, 8'h00);
    rd_reg(GRTS_ADDR_RX_TUNE, GRTS_RST_RX_TUNE);
    rd_reg(GRTS_ADDR_SHAPE, GRTS_RST_SHAPE);
    $display("misc done");
  endtask
  // mid-run reset with E1 selected: fields clear, standard shape returns
  task t_reset;
    @(posedge clk);
    rst <= 1'b1;
    e1_mode <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk("std", 8'h00, stdp);
    chk("wire", 8'h00, 8'(wire_size));
    @(posedge clk);
    #1;
    chk("std", 8'hFF, stdp);
    chk("custom", 8'h00, cust);
    rd_reg(GRTS_ADDR_RX_TUNE, GRTS_RST_RX_TUNE);
    rd_reg(GRTS_ADDR_SHAPE, GRTS_RST_SHAPE);
    @(posedge clk);
    e1_mode <= 1'b0;
    $display("reset done");
  endtask
  initial
  begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_misc;
    t_tune;
    t_shape;
    rd_reg(GRTS_ADDR_RX_TUNE, 8'hFF);
    t_reset;
    complete_run;
  end
endmodule
`default_nettype wire
